// ---- common/timer16_pkg.sv ----
// Shared constants, mode encoding and mode decode helpers for the dual 16-bit timer.
package timer16_pkg;

    // Local register offsets inside one timer instance; io_addr[3] picks the instance.
    localparam logic [2:0] OFS_CTRL_B = 3'h0;
    localparam logic [2:0] OFS_CNT_L = 3'h1;
    localparam logic [2:0] OFS_CNT_H = 3'h2;
    localparam logic [2:0] OFS_CMP0_L = 3'h3;
    localparam logic [2:0] OFS_CMP0_H = 3'h4;
    localparam logic [2:0] OFS_CMP1_L = 3'h5;
    localparam logic [2:0] OFS_CMP1_H = 3'h6;

    // Control register B field positions.
    localparam int CTRL_FILTER_BIT = 7;
    localparam int CTRL_EDGE_BIT = 6;
    localparam int CTRL_WAVE_HI = 4;
    localparam int CTRL_WAVE_LO = 3;
    localparam int CTRL_CS_HI = 2;
    localparam logic [7:0] CTRL_B_WMASK = 8'hdf;
    localparam logic [7:0] CTRL_B_RESET = 8'h00;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    // Clock select codes.
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [2:0] CS_ALT6 = 3'h6;
    localparam logic [2:0] CS_ALT7 = 3'h7;

    // Prescaler tap masks: a tap fires when all masked prescaler bits are one.
    localparam logic [9:0] PRE_MASK_8 = 10'h007;
    localparam logic [9:0] PRE_MASK_16 = 10'h00f;
    localparam logic [9:0] PRE_MASK_32 = 10'h01f;
    localparam logic [9:0] PRE_MASK_64 = 10'h03f;
    localparam logic [9:0] PRE_MASK_256 = 10'h0ff;
    localparam logic [9:0] PRE_MASK_1024 = 10'h3ff;

    localparam logic [15:0] TOP_8BIT = 16'h00ff;
    localparam logic [15:0] TOP_9BIT = 16'h01ff;
    localparam logic [15:0] TOP_10BIT = 16'h03ff;
    localparam logic [15:0] TOP_MAX = 16'hffff;

    typedef enum logic [3:0] {
        MODE_NORMAL = 4'h0, MODE_PC8 = 4'h1, MODE_PC9 = 4'h2, MODE_PC10 = 4'h3,
        MODE_CTC_CMP = 4'h4, MODE_FAST8 = 4'h5, MODE_FAST9 = 4'h6, MODE_FAST10 = 4'h7,
        MODE_PFC_CAP = 4'h8, MODE_PFC_CMP = 4'h9, MODE_PC_CAP = 4'ha, MODE_PC_CMP = 4'hb,
        MODE_CTC_CAP = 4'hc, MODE_RESERVED = 4'hd, MODE_FAST_CAP = 4'he, MODE_FAST_CMP = 4'hf
    } wave_mode_type;

    function automatic logic mode_dual_slope(wave_mode_type m);
        return m inside {MODE_PC8, MODE_PC9, MODE_PC10, MODE_PFC_CAP, MODE_PFC_CMP, MODE_PC_CAP, MODE_PC_CMP};
    endfunction

    function automatic logic mode_cap_top(wave_mode_type m);
        return m inside {MODE_PFC_CAP, MODE_PC_CAP, MODE_CTC_CAP, MODE_FAST_CAP};
    endfunction

    function automatic logic mode_cmp_top(wave_mode_type m);
        return m inside {MODE_CTC_CMP, MODE_PFC_CMP, MODE_PC_CMP, MODE_FAST_CMP};
    endfunction

    function automatic logic [15:0] mode_fixed_top(wave_mode_type m);
        if (m inside {MODE_PC8, MODE_FAST8}) begin
            return TOP_8BIT;
        end
        if (m inside {MODE_PC9, MODE_FAST9}) begin
            return TOP_9BIT;
        end
        if (m inside {MODE_PC10, MODE_FAST10}) begin
            return TOP_10BIT;
        end
        return TOP_MAX;
    endfunction

endpackage

// ---- rtl/timer16_ctl.sv ----
// Dual 16-bit timer: control register B, counter, two compare registers, capture and prescaler.
`timescale 1ns/1ps
`default_nettype none

module timer16_ctl (
    input wire logic clk,
    input wire logic srst,
    input wire logic [3:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    input wire logic [3:0] wave_mode_lower_bits,
    input wire logic [1:0] capture_input_pin,
    input wire logic external_count_pin,
    output logic [1:0][3:0] wave_mode,
    output logic [1:0][15:0] counter_value,
    output logic [1:0][15:0] capture_register,
    output logic [1:0] capture_flag,
    output logic [3:0] compare_match
);

    logic [1:0][15:0] cnt_all;
    logic [1:0][1:0][15:0] cmp_all;
    logic [1:0][7:0] ctrl_all;
    logic [9:0] presc_r, presc_nxt;
    logic [7:0] temp_r, temp_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic [2:0] ext_sync_r, ext_sync_nxt;
    logic ext_clean_r, ext_clean_nxt;
    logic ext_ref_r, ext_ref_nxt;
    logic ext_rise, ext_fall;

    function automatic logic pre_hit(logic [9:0] cnt, logic [9:0] mask);
        return (cnt & mask) == mask;
    endfunction

    // Shared prescaler, external pin sampling, temp byte and read data.
    always_comb begin
        presc_nxt = presc_r + 10'h001;
        ext_sync_nxt = {ext_sync_r[1:0], external_count_pin};
        ext_clean_nxt = (ext_sync_r[1] == ext_sync_r[2]) ? ext_sync_r[2] : ext_clean_r;
        ext_ref_nxt = ext_clean_r;
        temp_nxt = temp_r;
        rdata_nxt = rdata_r;
        if (io_wr && (io_addr[2:0] inside {timer16_pkg::OFS_CNT_H, timer16_pkg::OFS_CMP0_H, timer16_pkg::OFS_CMP1_H})) begin
            temp_nxt = io_wdata;
        end
        if (io_rd) begin
            case (io_addr[2:0])
                timer16_pkg::OFS_CTRL_B: rdata_nxt = ctrl_all[io_addr[3]] & timer16_pkg::CTRL_B_WMASK;
                timer16_pkg::OFS_CNT_L: begin
                    rdata_nxt = cnt_all[io_addr[3]][7:0];
                    temp_nxt = cnt_all[io_addr[3]][15:8];
                end
                timer16_pkg::OFS_CMP0_L: begin
                    rdata_nxt = cmp_all[io_addr[3]][0][7:0];
                    temp_nxt = cmp_all[io_addr[3]][0][15:8];
                end
                timer16_pkg::OFS_CMP1_L: begin
                    rdata_nxt = cmp_all[io_addr[3]][1][7:0];
                    temp_nxt = cmp_all[io_addr[3]][1][15:8];
                end
                timer16_pkg::OFS_CNT_H,
                timer16_pkg::OFS_CMP0_H,
                timer16_pkg::OFS_CMP1_H: rdata_nxt = temp_r;
                default: rdata_nxt = timer16_pkg::BYTE_RESET;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            presc_r <= 10'h000;
            ext_sync_r <= 3'h0;
            ext_clean_r <= 1'b0;
            ext_ref_r <= 1'b0;
            temp_r <= timer16_pkg::BYTE_RESET;
            rdata_r <= timer16_pkg::BYTE_RESET;
        end else begin
            presc_r <= presc_nxt;
            ext_sync_r <= ext_sync_nxt;
            ext_clean_r <= ext_clean_nxt;
            ext_ref_r <= ext_ref_nxt;
            temp_r <= temp_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign ext_rise = ext_clean_r & ~ext_ref_r;
    assign ext_fall = ~ext_clean_r & ext_ref_r;
    assign io_rdata = rdata_r;

    for (genvar i = 0; i < 2; i++) begin : g_timer
        logic [7:0] ctrl_r, ctrl_nxt;
        logic [15:0] cnt_r, cnt_nxt, cap_r, cap_nxt, top;
        logic [1:0][15:0] cmp_r, cmp_nxt;
        logic dir_r, dir_nxt, block_r, block_nxt;
        logic [2:0] sync_r, sync_nxt;
        logic [3:0] hist_r, hist_nxt;
        logic clean_r, clean_nxt, filt_r, filt_nxt, ref_r, ref_nxt;
        logic cap_pulse_r, cap_pulse_nxt;
        logic [1:0] match_r, match_nxt;
        logic tick, wr_here, cap_evt, rev;
        timer16_pkg::wave_mode_type mode;

        assign wr_here = io_wr && (io_addr[3] == 1'(i));

        // Timer tick selection from the shared prescaler or the external pin.
        always_comb begin
            unique case (ctrl_r[timer16_pkg::CTRL_CS_HI:0])
                timer16_pkg::CS_STOP: tick = 1'b0;
                timer16_pkg::CS_DIV1: tick = 1'b1;
                timer16_pkg::CS_DIV8: tick = pre_hit(presc_r, timer16_pkg::PRE_MASK_8);
                timer16_pkg::CS_DIV64: tick = pre_hit(presc_r, timer16_pkg::PRE_MASK_64);
                timer16_pkg::CS_DIV256: tick = pre_hit(presc_r, timer16_pkg::PRE_MASK_256);
                timer16_pkg::CS_DIV1024: tick = pre_hit(presc_r, timer16_pkg::PRE_MASK_1024);
                timer16_pkg::CS_ALT6: tick = (i == 0) ? ext_fall : pre_hit(presc_r, timer16_pkg::PRE_MASK_16);
                timer16_pkg::CS_ALT7: tick = (i == 0) ? ext_rise : pre_hit(presc_r, timer16_pkg::PRE_MASK_32);
            endcase
        end

        always_comb begin
            mode = timer16_pkg::wave_mode_type'({ctrl_r[timer16_pkg::CTRL_WAVE_HI:timer16_pkg::CTRL_WAVE_LO],
                wave_mode_lower_bits[2*i+:2]});
            if (timer16_pkg::mode_cap_top(mode)) begin
                top = cap_r;
            end else if (timer16_pkg::mode_cmp_top(mode)) begin
                top = cmp_r[0];
            end else begin
                top = timer16_pkg::mode_fixed_top(mode);
            end
            ctrl_nxt = ctrl_r;
            cnt_nxt = cnt_r;
            cmp_nxt = cmp_r;
            cap_nxt = cap_r;
            dir_nxt = dir_r;
            block_nxt = block_r;
            match_nxt = 2'b00;
            cap_pulse_nxt = 1'b0;
            rev = 1'b0;
            sync_nxt = {sync_r[1:0], capture_input_pin[i]};
            clean_nxt = (sync_r[1] == sync_r[2]) ? sync_r[2] : clean_r;
            hist_nxt = {hist_r[2:0], clean_r};
            if (!ctrl_r[timer16_pkg::CTRL_FILTER_BIT]) begin
                filt_nxt = clean_r;
            end else if ((&hist_r) || (~|hist_r)) begin
                filt_nxt = hist_r[0];
            end else begin
                filt_nxt = filt_r;
            end
            ref_nxt = filt_r;
            cap_evt = (filt_r != ref_r) && (filt_r == ctrl_r[timer16_pkg::CTRL_EDGE_BIT])
                && !timer16_pkg::mode_cap_top(mode);
            if (cap_evt) begin
                cap_nxt = cnt_r;
                cap_pulse_nxt = 1'b1;
            end
            if (tick) begin
                for (int k = 0; k < 2; k++) begin
                    match_nxt[k] = (cnt_r == cmp_r[k]) && !block_r;
                end
                block_nxt = 1'b0;
                if (timer16_pkg::mode_cap_top(mode) && (cnt_r == top)) begin
                    cap_pulse_nxt = 1'b1;
                end
                if (timer16_pkg::mode_dual_slope(mode)) begin
                    rev = dir_r ? (cnt_r == timer16_pkg::WORD_RESET) : (cnt_r >= top);
                    dir_nxt = dir_r ^ rev;
                    cnt_nxt = (dir_r ^ rev) ? cnt_r - 16'h0001 : cnt_r + 16'h0001;
                end else begin
                    cnt_nxt = (cnt_r >= top) ? timer16_pkg::WORD_RESET : cnt_r + 16'h0001;
                end
            end
            if (wr_here) begin
                case (io_addr[2:0])
                    timer16_pkg::OFS_CTRL_B: ctrl_nxt = io_wdata & timer16_pkg::CTRL_B_WMASK;
                    timer16_pkg::OFS_CNT_L: begin
                        cnt_nxt = {temp_r, io_wdata};
                        block_nxt = 1'b1;
                    end
                    timer16_pkg::OFS_CMP0_L: cmp_nxt[0] = {temp_r, io_wdata};
                    timer16_pkg::OFS_CMP1_L: cmp_nxt[1] = {temp_r, io_wdata};
                    default: ;
                endcase
            end
        end

        always_ff @(posedge clk) begin
            if (srst) begin
                ctrl_r <= timer16_pkg::CTRL_B_RESET;
                cnt_r <= timer16_pkg::WORD_RESET;
                cmp_r <= {timer16_pkg::WORD_RESET, timer16_pkg::WORD_RESET};
                cap_r <= timer16_pkg::WORD_RESET;
                dir_r <= 1'b0;
                block_r <= 1'b0;
                sync_r <= 3'h0;
                hist_r <= 4'h0;
                clean_r <= 1'b0;
                filt_r <= 1'b0;
                ref_r <= 1'b0;
                cap_pulse_r <= 1'b0;
                match_r <= 2'b00;
            end else begin
                ctrl_r <= ctrl_nxt;
                cnt_r <= cnt_nxt;
                cmp_r <= cmp_nxt;
                cap_r <= cap_nxt;
                dir_r <= dir_nxt;
                block_r <= block_nxt;
                sync_r <= sync_nxt;
                hist_r <= hist_nxt;
                clean_r <= clean_nxt;
                filt_r <= filt_nxt;
                ref_r <= ref_nxt;
                cap_pulse_r <= cap_pulse_nxt;
                match_r <= match_nxt;
            end
        end

        assign cnt_all[i] = cnt_r;
        assign cmp_all[i] = cmp_r;
        assign ctrl_all[i] = ctrl_r;
        assign counter_value[i] = cnt_r;
        assign capture_register[i] = cap_r;
        assign capture_flag[i] = cap_pulse_r;
        assign compare_match[2*i+:2] = match_r;
        assign wave_mode[i] = {ctrl_r[timer16_pkg::CTRL_WAVE_HI:timer16_pkg::CTRL_WAVE_LO], wave_mode_lower_bits[2*i+:2]};
    end

endmodule

`default_nettype wire

// ---- sim/cpu_model.sv ----
// Bus master model that issues byte and word accesses to the timer registers.
`timescale 1ns/1ps
`default_nettype none
module cpu_model (
    input wire logic clk,
    output logic [3:0] io_addr,
    output logic io_wr,
    output logic io_rd,
    output logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata
);
    initial begin
        io_addr = 4'h0;
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_wdata = 8'h00;
    end
    task automatic wr8(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        io_addr <= a;
        io_wdata <= d;
        io_wr <= 1'b1;
        @(posedge clk);
        io_wr <= 1'b0;
        io_wdata <= ~d;
    endtask
    task automatic rd8(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        io_addr <= a;
        io_rd <= 1'b1;
        @(posedge clk);
        io_rd <= 1'b0;
        #1;
        d = io_rdata;
    endtask
    // The high byte lands in the shared staging byte; the low write commits the word.
    task automatic wr16(input logic [3:0] a, input logic [15:0] v);
        wr8(a + 4'h1, v[15:8]);
        wr8(a, v[7:0]);
    endtask
    task automatic rd16(input logic [3:0] a, output logic [15:0] v);
        rd8(a, v[7:0]);
        rd8(a + 4'h1, v[15:8]);
    endtask
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
// Self-checking bench for the dual 16-bit timer.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic external_count_pin = 1'b0;
    logic [1:0] capture_input_pin = 2'h3;
    logic [3:0] wave_mode_lower_bits = 4'h0;
    logic [3:0] io_addr;
    logic io_wr, io_rd;
    logic [7:0] io_wdata, io_rdata;
    logic [1:0][3:0] wave_mode;
    logic [1:0][15:0] counter_value, capture_register;
    logic [1:0] capture_flag;
    logic [3:0] compare_match;
    int fails = 0;
    int n_tests = 0;
    int cyc = 0;
    int hits = 0;
    timer16_ctl timer16_ctl_inst (.clk, .srst, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata, .wave_mode_lower_bits,
        .capture_input_pin, .external_count_pin, .wave_mode, .counter_value, .capture_register, .capture_flag,
        .compare_match);
    cpu_model cpu_model_inst (.clk, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata);
    initial begin
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        hits <= hits + int'(compare_match[0] === 1'b1);
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    function automatic int div_of(input int c);
        int d[8] = '{0, 1, 8, 64, 256, 1024, 16, 32};
        return d[c];
    endfunction
    task automatic ctrl(input logic i, input logic [7:0] v);
        cpu_model_inst.wr8({i, timer16_pkg::OFS_CTRL_B}, v & timer16_pkg::CTRL_B_WMASK);
    endtask
    task automatic wait_change(input int i);
        logic [15:0] o;
        #1;
        o = counter_value[i];
        for (int t = 0; t < 2100 && counter_value[i] === o; t++) begin
            @(posedge clk);
            #1;
        end
    endtask
    task automatic pulse_cap(input logic lvl, output int lat);
        repeat (20) @(posedge clk);
        capture_input_pin[0] <= lvl;
        for (lat = 0; lat < 30; lat++) begin
            @(posedge clk);
            #1;
            if (capture_flag[0] === 1'b1) break;
        end
    endtask
    initial begin
        logic [7:0] b;
        logic [15:0] v, w;
        int l0, l1, t0;
        void'($urandom(32'h2d16));
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        for (int a = 0; a < 16; a++) begin
            cpu_model_inst.rd8(4'(a), b);
            chk("reset value", 16'h0000, {8'h00, b});
        end
        for (int i = 0; i < 2; i++) begin
            b = 8'($urandom) & 8'hd8;
            wave_mode_lower_bits <= 4'($urandom);
            ctrl(i[0], b);
            cpu_model_inst.rd8({i[0], 3'h0}, w[7:0]);
            chk("control b", {8'h00, b}, {8'h00, w[7:0]});
            chk("wave mode", {12'h000, b[4:3], wave_mode_lower_bits[2*i+:2]}, {12'h000, wave_mode[i]});
            for (int k = 1; k < 6; k += 2) begin
                v = 16'($urandom);
                cpu_model_inst.wr16({i[0], 3'(k)}, v);
                cpu_model_inst.rd16({i[0], 3'(k)}, w);
                chk("word readback", v, w);
            end
            ctrl(i[0], 8'h00);
        end
        wave_mode_lower_bits <= 4'h0;
        cpu_model_inst.wr8(4'h4, 8'ha5);
        cpu_model_inst.wr8(4'hd, 8'h3c);
        cpu_model_inst.rd16(4'hd, w);
        chk("shared staging byte", 16'ha53c, w);
        for (int i = 0; i < 2; i++) begin
            for (int c = 1; c < (i ? 8 : 6); c++) begin
                ctrl(i[0], 8'(c));
                wait_change(i);
                t0 = cyc;
                wait_change(i);
                chk("tick spacing", 16'(div_of(c)), 16'(cyc - t0));
            end
            ctrl(i[0], 8'h00);
        end
        for (int c = 6; c < 8; c++) begin
            ctrl(1'b0, 8'(c));
            v = counter_value[0];
            external_count_pin <= 1'b1;
            repeat (10) @(posedge clk);
            chk("count on rise", v + 16'(c == 7), counter_value[0]);
            external_count_pin <= 1'b0;
            repeat (10) @(posedge clk);
            chk("count after fall", v + 16'h0001, counter_value[0]);
        end
        // Stop the counter before loading it so no match is lost.
        ctrl(1'b0, 8'h00);
        v = 16'($urandom_range(16'hfff0, 16'h0010));
        cpu_model_inst.wr16(4'h3, v);
        cpu_model_inst.wr16(4'h5, v);
        cpu_model_inst.wr16(4'h1, v - 16'h0008);
        ctrl(1'b0, 8'h01);
        for (int t = 0; t < 40 && compare_match[0] !== 1'b1; t++) begin
            @(posedge clk);
            #1;
        end
        chk("count at match", v + 16'h0001, counter_value[0]);
        chk("second compare match", 16'h0001, {15'h0000, compare_match[1]});
        // Let the pulse just seen reach the hit counter before taking the baseline.
        @(posedge clk);
        #1;
        l0 = hits;
        cpu_model_inst.wr16(4'h1, v);
        repeat (20) @(posedge clk);
        chk("matches after count write", 16'h0000, 16'(hits - l0));
        ctrl(1'b0, 8'h41);
        pulse_cap(1'b0, l0);
        chk("fall with rise select", 16'h001e, 16'(l0));
        pulse_cap(1'b1, l0);
        chk("capture seen", 16'h0001, 16'(l0 < 30));
        ctrl(1'b0, 8'hc1);
        pulse_cap(1'b0, l1);
        pulse_cap(1'b1, l1);
        chk("filter delay", 16'h0004, 16'(l1 - l0));
        ctrl(1'b0, 8'h01);
        pulse_cap(1'b0, l1);
        chk("fall select", 16'h0001, 16'(l1 < 30));
        ctrl(1'b0, 8'h59);
        v = capture_register[0];
        pulse_cap(1'b1, l1);
        pulse_cap(1'b0, l1);
        chk("capture in top mode", v, capture_register[0]);
        complete_run();
    end
    initial begin
        repeat (40000) @(posedge clk);
        fails++;
        complete_run();
    end
endmodule
`default_nettype wire

// ---- sim/timer16_asserts.sv ----
// Assertions on bus, counting, compare and capture behaviour of the dual timer.
`timescale 1ns/1ps
`default_nettype none
module timer16_asserts (
    input wire logic clk,
    input wire logic srst,
    input wire logic [3:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    input wire logic [3:0] wave_mode_lower_bits,
    input wire logic [1:0][3:0] wave_mode,
    input wire logic [1:0][15:0] counter_value,
    input wire logic [1:0][15:0] capture_register,
    input wire logic [1:0] capture_flag,
    input wire logic [3:0] compare_match
);
    // Shadows of the staging byte, control B and compare words, kept from bus traffic.
    logic [7:0] tmp_r;
    logic [1:0][4:0] ctl_r;
    logic [3:0][15:0] cmp_r;
    logic [2:0] ofs;
    logic [1:0] idx;
    assign ofs = io_addr[2:0];
    assign idx = {io_addr[3], ofs == 3'h5};
    always_ff @(posedge clk) begin
        if (srst) begin
            tmp_r <= 8'h00;
            ctl_r <= '0;
            cmp_r <= '0;
        end else if (io_wr && ofs == 3'h0) begin
            ctl_r[io_addr[3]] <= io_wdata[4:0];
        end else if (io_wr && ofs inside {3'h2, 3'h4, 3'h6}) begin
            tmp_r <= io_wdata;
        end else if (io_wr && ofs inside {3'h3, 3'h5}) begin
            cmp_r[idx] <= {tmp_r, io_wdata};
        end else if (io_rd && ofs == 3'h1) begin
            tmp_r <= counter_value[io_addr[3]][15:8];
        end else if (io_rd && ofs inside {3'h3, 3'h5}) begin
            tmp_r <= cmp_r[idx][15:8];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    a_rdata_holds: assert property (!$past(io_rd) |-> $stable(io_rdata))
        else $error("read data moved without a read");
    a_ctrl_reserved: assert property ($past(io_rd) && $past(io_addr[2:0]) == 3'h0 |-> !io_rdata[5])
        else $error("reserved control bit read as one");
    for (genvar i = 0; i < 2; i++) begin : g_inst
        a_mode_join: assert property (wave_mode[i] == {ctl_r[i][4:3], wave_mode_lower_bits[2*i+:2]})
            else $error("wave mode is not control bits joined to lower bits");
        a_stop_holds: assert property ($past(ctl_r[i][2:0]) == 3'h0 && !$past(io_wr) |-> $stable(counter_value[i]))
            else $error("stopped counter moved");
        a_div1_step: assert property ($past(ctl_r[i][2:0]) == 3'h1 && $past(wave_mode[i]) == 4'h0 && !$past(io_wr)
            |-> counter_value[i] == $past(counter_value[i]) + 16'h0001) else $error("counter did not step by one");
    end
    for (genvar j = 0; j < 4; j++) begin : g_cmp
        a_match_value: assert property (compare_match[j] |-> $past(counter_value[j / 2]) == $past(cmp_r[j]))
            else $error("compare pulse without equal count");
    end
    a_match_hit: assert property ($past(ctl_r[0][2:0]) == 3'h1 && ctl_r[0][2:0] == 3'h1 && !$past(io_wr) && !io_wr
        && counter_value[0] == cmp_r[0] |=> compare_match[0]) else $error("equal count gave no compare pulse");
    a_write_blocks: assert property ((io_wr && io_addr == 4'h1 && ctl_r[0][2:0] == 3'h1)
        ##1 (counter_value[0] == cmp_r[0]) |=> !compare_match[0]) else $error("match right after a count write");
    a_capture_copy: assert property (capture_flag[0] && !(wave_mode[0][3] && !wave_mode[0][0])
        |-> capture_register[0] == $past(counter_value[0])) else $error("capture did not copy the count");
endmodule
bind timer16_ctl timer16_asserts timer16_asserts_inst (.clk, .srst, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata,
    .wave_mode_lower_bits, .wave_mode, .counter_value, .capture_register, .capture_flag, .compare_match);
`default_nettype wire
